//--- logic/pll_latch_pkg.sv
// Constants shared by the dual synthesizer latch bank
package pll_latch_pkg;
  localparam int WORD_BITS = 22;
  localparam int REF_BITS = 14;
  localparam int SWALLOW_BITS = 6;
  localparam int MAIN_BITS = 11;
  // Word field positions
  localparam int SEL_LOW_POS = 0;
  localparam int SEL_HIGH_POS = 1;
  localparam int REF_LSB = 2;
  localparam int SWALLOW_LSB = 2;
  localparam int MAIN_LSB = 9;
  localparam int DET_SENSE_POS = 17;
  localparam int PUMP_CUR_POS = 18;
  localparam int PUMP_HIZ_POS = 19;
  localparam int PRESCALE_POS = 20;
  localparam int SLEEP_POS = 21;
  // Latch select codes, high bit then low bit
  localparam logic [1:0] SEL_IF_REF = 2'h0;
  localparam logic [1:0] SEL_IF_FB = 2'h1;
  localparam logic [1:0] SEL_RF_REF = 2'h2;
  localparam logic [1:0] SEL_RF_FB = 2'h3;
  // Reset values of the latches
  localparam logic [21:0] LATCH_RESET = 22'h000000;
  localparam logic [5:0] BIT_COUNT_RESET = 6'h00;
endpackage

//--- logic/bit_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module bit_sync (
  input wire logic clk_i, // Destination clock
  input wire logic nrst_i, // Asynchronous reset, active low
  input wire logic en_i, // Clock enable
  input wire logic d_i, // Asynchronous level
  output logic q_o // Synchronised level
);
  typedef struct packed {
    logic s1;
    logic s2;
  } sync_state_type;
  sync_state_type st_reg;
  sync_state_type st_next;
  always_comb begin
    st_next = st_reg;
    if (en_i) begin
      st_next.s1 = d_i;
      st_next.s2 = st_reg.s1;
    end
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign q_o = st_reg.s2;
endmodule

//--- logic/serial_shifter.sv
// Link-side shift register clocked by the serial clock
`timescale 1ns/1ps
module serial_shifter (
  input wire logic sclk_i, // Serial clock from host
  input wire logic nrst_i, // Asynchronous reset, active low
  input wire logic serial_in_i, // Serial data, MSB first
  output logic [pll_latch_pkg::WORD_BITS-1:0] word_o // Shifted word
);
  import pll_latch_pkg::*;
  typedef struct packed {
    logic [WORD_BITS-1:0] shift;
  } shift_state_type;
  shift_state_type st_reg;
  shift_state_type st_next;
  always_comb begin
    st_next = st_reg;
    st_next.shift = {st_reg.shift[WORD_BITS-2:0], serial_in_i};
  end
  always_ff @(posedge sclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign word_o = st_reg.shift;
endmodule

//--- logic/dual_pll_divider_latches.sv
// Serially programmed divider and control latches of a dual synthesizer
//
// What this block does
// - Select bits 0,0 load the 14-bit IF reference divider.
// - IF sense bit chooses phase detector polarity for VCO slope.
// - IF pump-disable one puts IF charge pump into high impedance.
// - IF pump-current bit picks 1.25 mA at zero, 4.375 mA at one.
// - Select bits 0,1 load IF swallow 6-bit and main 11-bit counts.
// - One bit selects IF prescaler 8/9 or 16/17.
// - Select bits 1,0 load the 14-bit RF reference divider.
// - Select bits 1,1 load the RF swallow and main counts.
// - One bit selects RF prescaler 32/33 or 64/65.
// - Host shifts 22 bits on rising clock; strobe rise transfers word.
`timescale 1ns/1ps
module dual_pll_divider_latches (
  input wire logic mclk_i, // System clock, 100 MHz
  input wire logic nrst_i, // Asynchronous reset, active low
  input wire logic ce_i, // Clock enable, freezes mclk-domain state when low; the serial shifter keeps shifting
  input wire logic sclk_i, // Serial clock from host, link domain
  input wire logic serial_in_i, // Serial data from host
  input wire logic word_strobe_i, // Latch strobe from host
  output logic [pll_latch_pkg::REF_BITS-1:0] if_ref_div_o, // IF reference count
  output logic if_detector_sense_o, // IF polarity, 1 for positive VCO
  output logic if_pump_hiz_o, // IF charge pump high impedance
  output logic if_pump_current_sel_o, // IF pump 0:1.25 mA 1:4.375 mA
  output logic [pll_latch_pkg::SWALLOW_BITS-1:0] if_swallow_o, // IF swallow count
  output logic [pll_latch_pkg::MAIN_BITS-1:0] if_main_o, // IF main count
  output logic if_prescale_sel_o, // IF prescaler 0:8/9 1:16/17
  output logic if_sleep_o, // IF power-down
  output logic [pll_latch_pkg::REF_BITS-1:0] rf_ref_div_o, // RF reference count
  output logic [pll_latch_pkg::WORD_BITS-1:0] rf_ref_latch_o, // Whole RF reference latch
  output logic [pll_latch_pkg::SWALLOW_BITS-1:0] rf_swallow_o, // RF swallow count
  output logic [pll_latch_pkg::MAIN_BITS-1:0] rf_main_o, // RF main count
  output logic rf_prescale_sel_o, // RF prescaler 0:32/33 1:64/65
  output logic rf_sleep_o, // RF power-down
  output logic [3:0] loaded_o // One bit per latch written since reset
);
  import pll_latch_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_LOAD = 2'b10
  } load_state_type;

  typedef struct packed {
    load_state_type fsm;
    logic strobe_d;
    logic [WORD_BITS-1:0] hold;
    logic [WORD_BITS-1:0] if_ref_latch;
    logic [WORD_BITS-1:0] if_fb_latch;
    logic [WORD_BITS-1:0] rf_ref_latch;
    logic [WORD_BITS-1:0] rf_fb_latch;
    logic [3:0] loaded;
  } bank_state_type;

  bank_state_type st_reg;
  bank_state_type st_next;
  logic [WORD_BITS-1:0] link_word;
  logic strobe_sync;
  logic [WORD_BITS-1:0] word_sync [2];

  serial_shifter u_shifter (
    .sclk_i(sclk_i),
    .nrst_i(nrst_i),
    .serial_in_i(serial_in_i),
    .word_o(link_word)
  );

  bit_sync u_strobe_sync (
    .clk_i(mclk_i),
    .nrst_i(nrst_i),
    .en_i(ce_i),
    .d_i(word_strobe_i),
    .q_o(strobe_sync)
  );

  // The shift word is quiet while the strobe is high, because the host
  // stops the serial clock before raising it. Two stages keep the bus
  // metastability-safe; the word is only sampled after the strobe settles.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      word_sync[0] <= LATCH_RESET;
      word_sync[1] <= LATCH_RESET;
    end else if (ce_i) begin
      word_sync[0] <= link_word;
      word_sync[1] <= word_sync[0];
    end
  end

  function automatic logic [1:0] latch_sel(input logic [WORD_BITS-1:0] w);
    latch_sel = {w[SEL_HIGH_POS], w[SEL_LOW_POS]};
  endfunction

  always_comb begin
    st_next = st_reg;
    if (ce_i) begin
      st_next.strobe_d = strobe_sync;
      case (st_reg.fsm)
        ST_IDLE: begin
          if (strobe_sync && !st_reg.strobe_d) begin
            st_next.fsm = ST_WAIT;
          end
        end
        ST_WAIT: begin
          // One extra cycle lets the word pipeline settle past the strobe
          st_next.hold = word_sync[1];
          st_next.fsm = ST_LOAD;
        end
        ST_LOAD: begin
          st_next.fsm = ST_IDLE;
          case (latch_sel(st_reg.hold))
            SEL_IF_REF: begin
              st_next.if_ref_latch = st_reg.hold;
              st_next.loaded[0] = 1'b1;
            end
            SEL_IF_FB: begin
              st_next.if_fb_latch = st_reg.hold;
              st_next.loaded[1] = 1'b1;
            end
            SEL_RF_REF: begin
              st_next.rf_ref_latch = st_reg.hold;
              st_next.loaded[2] = 1'b1;
            end
            SEL_RF_FB: begin
              st_next.rf_fb_latch = st_reg.hold;
              st_next.loaded[3] = 1'b1;
            end
            default: begin
              st_next.loaded = st_reg.loaded;
            end
          endcase
        end
        default: begin
          st_next.fsm = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg.fsm <= ST_IDLE;
      st_reg.strobe_d <= 1'b0;
      st_reg.hold <= LATCH_RESET;
      st_reg.if_ref_latch <= LATCH_RESET;
      st_reg.if_fb_latch <= LATCH_RESET;
      st_reg.rf_ref_latch <= LATCH_RESET;
      st_reg.rf_fb_latch <= LATCH_RESET;
      st_reg.loaded <= 4'h0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign if_ref_div_o = st_reg.if_ref_latch[REF_LSB +: REF_BITS];
  assign if_detector_sense_o = st_reg.if_ref_latch[DET_SENSE_POS];
  assign if_pump_hiz_o = st_reg.if_ref_latch[PUMP_HIZ_POS];
  assign if_pump_current_sel_o = st_reg.if_ref_latch[PUMP_CUR_POS];
  assign if_swallow_o = st_reg.if_fb_latch[SWALLOW_LSB +: SWALLOW_BITS];
  assign if_main_o = st_reg.if_fb_latch[MAIN_LSB +: MAIN_BITS];
  assign if_prescale_sel_o = st_reg.if_fb_latch[PRESCALE_POS];
  assign if_sleep_o = st_reg.if_fb_latch[SLEEP_POS];
  assign rf_ref_div_o = st_reg.rf_ref_latch[REF_LSB +: REF_BITS];
  assign rf_ref_latch_o = st_reg.rf_ref_latch;
  assign rf_swallow_o = st_reg.rf_fb_latch[SWALLOW_LSB +: SWALLOW_BITS];
  assign rf_main_o = st_reg.rf_fb_latch[MAIN_LSB +: MAIN_BITS];
  assign rf_prescale_sel_o = st_reg.rf_fb_latch[PRESCALE_POS];
  assign rf_sleep_o = st_reg.rf_fb_latch[SLEEP_POS];
  assign loaded_o = st_reg.loaded;
endmodule

//--- bench/pll_latch_sva.sv
// Assertion checker for the divider latch bank
`timescale 1ns/1ps
module pll_latch_sva (
  input wire logic mclk_i, nrst_i, ce_i, sclk_i, serial_in_i, word_strobe_i,
  input wire logic [13:0] if_ref_div_o,
  input wire logic if_detector_sense_o, if_pump_hiz_o, if_pump_current_sel_o,
  input wire logic [5:0] if_swallow_o, rf_swallow_o,
  input wire logic [10:0] if_main_o, rf_main_o,
  input wire logic if_prescale_sel_o, if_sleep_o, rf_prescale_sel_o, rf_sleep_o,
  input wire logic [21:0] rf_ref_latch_o
);
  logic [21:0] sh;
  // Own copy of the word; host keeps sclk quiet while strobe is high
  always_ff @(posedge sclk_i or negedge nrst_i) begin
    if (!nrst_i) sh <= 22'h000000;
    else sh <= {sh[20:0], serial_in_i};
  end
  default clocking @(posedge mclk_i); endclocking
  // A strobe seen while the bank is frozen is lost on purpose
  default disable iff (!nrst_i || !ce_i);
  property p_if_ref;
    $rose(word_strobe_i) && sh[1:0] == 2'h0 |-> ##[3:7] if_ref_div_o == sh[15:2];
  endproperty
  a_if_ref: assert property (p_if_ref) else $error("if ref");
  property p_if_ctl;
    $rose(word_strobe_i) && sh[1:0] == 2'h0 |->
      ##[3:7] {if_pump_hiz_o, if_pump_current_sel_o, if_detector_sense_o} == sh[19:17];
  endproperty
  a_if_ctl: assert property (p_if_ctl) else $error("if ctl");
  property p_if_ab;
    $rose(word_strobe_i) && sh[1:0] == 2'h1 |-> ##[3:7] {if_main_o, if_swallow_o} == {sh[19:9], sh[7:2]};
  endproperty
  a_if_ab: assert property (p_if_ab) else $error("if ab");
  property p_if_pre;
    $rose(word_strobe_i) && sh[1:0] == 2'h1 |-> ##[3:7] {if_sleep_o, if_prescale_sel_o} == sh[21:20];
  endproperty
  a_if_pre: assert property (p_if_pre) else $error("if pre");
  property p_rf_ref;
    $rose(word_strobe_i) && sh[1:0] == 2'h2 |-> ##[3:7] rf_ref_latch_o == sh;
  endproperty
  a_rf_ref: assert property (p_rf_ref) else $error("rf ref");
  property p_rf_ab;
    $rose(word_strobe_i) && sh[1:0] == 2'h3 |-> ##[3:7] {rf_main_o, rf_swallow_o} == {sh[19:9], sh[7:2]};
  endproperty
  a_rf_ab: assert property (p_rf_ab) else $error("rf ab");
  property p_rf_pre;
    $rose(word_strobe_i) && sh[1:0] == 2'h3 |-> ##[3:7] {rf_sleep_o, rf_prescale_sel_o} == sh[21:20];
  endproperty
  a_rf_pre: assert property (p_rf_pre) else $error("rf pre");
  property p_hold;
    !word_strobe_i [*8] |=> $stable(rf_ref_latch_o) && $stable(if_main_o);
  endproperty
  a_hold: assert property (p_hold) else $error("latch moved");
endmodule
bind dual_pll_divider_latches pll_latch_sva u_sva (.*);

//--- bench/host_link_model.sv
// Host side of the three-wire programming link
`timescale 1ns/1ps
module host_link_model (
  output logic sclk_o, // Serial clock, still outside frames
  output logic data_o, // Serial data
  output logic strobe_o // Word strobe
);
  initial begin
    sclk_o = 1'b0;
    data_o = 1'b0;
    strobe_o = 1'b0;
  end
  // 22 bits MSB first, strobe after sclk stops
  task automatic send(input logic [21:0] w);
    #7;
    for (int i = 21; i >= 0; i--) begin
      data_o = w[i];
      #40 sclk_o = 1'b1;
      #40 sclk_o = 1'b0;
    end
    // Released data flips so a stale bit cannot pass
    data_o = ~data_o;
    #33 strobe_o = 1'b1;
    #80 strobe_o = 1'b0;
    #120;
  endtask
endmodule

//--- bench/tb_top.sv
// Self-checking bench for the divider latch bank
`timescale 1ns/1ps
module tb_top;
  logic mclk_i, nrst_i, ce_i, sclk_i, serial_in_i, word_strobe_i;
  logic [13:0] if_ref_div_o, rf_ref_div_o;
  logic if_detector_sense_o, if_pump_hiz_o, if_pump_current_sel_o, if_prescale_sel_o;
  logic if_sleep_o, rf_prescale_sel_o, rf_sleep_o;
  logic [5:0] if_swallow_o, rf_swallow_o;
  logic [10:0] if_main_o, rf_main_o;
  logic [21:0] rf_ref_latch_o, w;
  logic [3:0] loaded_o;
  logic [21:0] e [4];
  int miscompares, tests_run;
  dual_pll_divider_latches dut (.*);
  host_link_model host (.sclk_o(sclk_i), .data_o(serial_in_i), .strobe_o(word_strobe_i));
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic check_all;
    check("if_ref", e[0][15:2], if_ref_div_o);
    check("if_sense", e[0][17], if_detector_sense_o);
    check("if_hiz", e[0][19], if_pump_hiz_o);
    check("if_cur", e[0][18], if_pump_current_sel_o);
    check("if_ab", {e[1][19:9], e[1][7:2]}, {if_main_o, if_swallow_o});
    check("if_pre", e[1][21:20], {if_sleep_o, if_prescale_sel_o});
    check("rf_ref", e[2], rf_ref_latch_o);
    check("rf_div", e[2][15:2], rf_ref_div_o);
    check("rf_ab", {e[3][19:9], e[3][7:2]}, {rf_main_o, rf_swallow_o});
    check("rf_pre", e[3][21:20], {rf_sleep_o, rf_prescale_sel_o});
  endtask
  task automatic final_report;
    if (miscompares == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  initial begin
    #100000;
    miscompares++;
    final_report;
  end
  initial begin
    miscompares = 0;
    tests_run = 0;
    nrst_i = 1'b0;
    ce_i = 1'b1;
    w = 22'h000000;
    for (int k = 0; k < 4; k++) e[k] = 22'h000000;
    repeat (3) @(negedge mclk_i);
    nrst_i = 1'b1;
    check_all;
    check("loaded", 4'h0, loaded_o);
    // Every select code, every control bit both ways
    for (int k = 0; k < 8; k++) begin
      // main count 2047 or 3, never below swallow
      w = {k[2], ~k[2], k[2] ? 11'h003 : 11'h7FF, 1'b0, k[2] ? 6'h03 : 6'h3F, k[1:0]};
      host.send(w);
      @(negedge mclk_i);
      e[k[1:0]] = w;
      check_all;
    end
    check("loaded", 4'hF, loaded_o);
    // Frozen bank misses a strobe, so every latch keeps its word
    ce_i = 1'b0;
    host.send(22'h3FFFFF);
    @(negedge mclk_i);
    ce_i = 1'b1;
    repeat (8) @(negedge mclk_i);
    check_all;
    // Mid-run reset clears every latch and the loaded flags
    nrst_i = 1'b0;
    for (int k = 0; k < 4; k++) e[k] = 22'h000000;
    repeat (2) @(negedge mclk_i);
    nrst_i = 1'b1;
    check_all;
    check("loaded_rst", 4'h0, loaded_o);
    host.send(22'h0FFFFD);
    @(negedge mclk_i);
    e[1] = 22'h0FFFFD;
    check_all;
    check("loaded_if_fb", 4'h2, loaded_o);
    final_report;
  end
endmodule
